// file: verilog/plf_top.sv
// Purpose: status indicators, data format and discrete I/O pacing
// Assumes: inputs synchronous to clk_sys; register reads answer next cycle
// Notes:   long counts are parameters so a simulation can shorten them
`include "plf_regs.svh"
`default_nettype none
module plf_top #(
    parameter int unsigned TICK_CYC   = `PLF_TICK_CYC,
    parameter int unsigned UPDATE_CYC = `PLF_UPDATE_CYC,
    parameter int unsigned ACT_CYC    = `PLF_ACT_CYC,
    parameter int unsigned IO_W       = 4,
    parameter logic [47:0] HW_ADDR    = 48'h02_00_00_00_00_01 // arbitrary
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [7:0]       addr,
    input  wire logic [31:0]      wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output logic [31:0]           rdata,
    input  wire logic             opt_present,
    input  wire plf_pkg::plf_net_t net,
    input  wire logic [31:0]      weight_raw,
    input  wire logic [31:0]      div_raw,
    input  wire logic [31:0]      float_raw,
    input  wire logic [IO_W-1:0]  plc_dout,
    input  wire logic [IO_W-1:0]  local_dout,
    input  wire logic [IO_W-1:0]  din,
    output logic [IO_W-1:0]       dout,
    output logic [IO_W-1:0]       plc_din,
    output logic [31:0]           data_word,
    output logic [3:0]            slot_en,
    output logic                  led_link,
    output plf_pkg::plf_led2_t    led_mod,
    output logic                  led_net,
    output logic                  led_act,
    output logic                  irq
);
    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    if (TICK_CYC < 2 || UPDATE_CYC < 2 || ACT_CYC < 1 || IO_W > 32) begin
        $error("plf_top: unsupported parameter values");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    plf_pkg::plf_fmt_t   fmt_q;
    plf_pkg::plf_ord_t   ord_q;
    plf_pkg::plf_blink_t bl_q;
    logic [2:0]  slots_q;
    logic [31:0] ip_q, mask_q, gw_q;
    logic [IO_W-1:0] out_map_q;
    logic        opt_q;
    logic [3:0]  evt_q, evt_mask_q;
    logic [31:0] tick_cnt_q, upd_cnt_q, act_cnt_q;
    logic [2:0]  phase_q;
    logic [3:0]  bl_cnt_q, bl_left_q;
    logic        link_q, fault_q;
    logic [3:0]  conns_q;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    wire         wr_cfg    = wr && addr == `PLF_A_CFG;
    wire         net_wr_ok = wr && opt_q;
    wire         wr_ip     = net_wr_ok && addr == `PLF_A_IP;
    wire         wr_mask   = net_wr_ok && addr == `PLF_A_NETMASK;
    wire         wr_gw     = net_wr_ok && addr == `PLF_A_GATEWAY;
    wire         wr_emask  = wr && addr == `PLF_A_EVT_MASK;
    wire         wr_map    = wr && addr == `PLF_A_OUT_MAP;
    wire         rd_evt    = rd && addr == `PLF_A_EVT;
    wire [1:0]   new_fmt   = wdata[`PLF_CFG_FMT_LSB +: 2];
    wire [1:0]   new_ord   = wdata[`PLF_CFG_ORD_LSB +: 2];
    wire [2:0]   new_slots = wdata[`PLF_CFG_SLOT_LSB +: 3];
    wire         slots_ok  = new_slots != 3'h0
                          && new_slots <= `PLF_SLOT_MAX;
    wire         fmt_chg   = wr_cfg && new_fmt != fmt_q;
    wire [31:0]  cfg_rd    = {25'h0, slots_q, ord_q, fmt_q};
    wire [31:0]  stat_rd   = {20'h00000, conns_q, net.dup_ip, net.fatal,
                              net.cfg_fail, net.mac_bad, net.ip_set,
                              link_q, opt_q, 1'h0};

    // ------------------------------------------------------------------
    // timers: flash tick and update cycle
    // ------------------------------------------------------------------
    wire tick     = tick_cnt_q == TICK_CYC - 1;
    wire upd_tick = upd_cnt_q == UPDATE_CYC - 1;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_q <= 32'h00000000;
            upd_cnt_q  <= 32'h00000000;
            phase_q    <= 3'h0;
        end else begin
            tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
            upd_cnt_q  <= upd_tick ? 32'h00000000 : upd_cnt_q + 32'h00000001;
            if (tick) begin
                phase_q <= phase_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fmt_q     <= plf_pkg::plf_fmt_t'(`PLF_FMT_RST);
            ord_q     <= plf_pkg::plf_ord_t'(`PLF_ORD_RST);
            slots_q   <= `PLF_SLOT_RST;
            slot_en   <= 4'h1;
            ip_q      <= 32'h00000000;
            mask_q    <= 32'h00000000;
            gw_q      <= 32'h00000000;
            out_map_q <= '0;
            opt_q     <= 1'b0;
        end else begin
            if (opt_present) begin
                opt_q <= 1'b1;
            end
            if (wr_cfg) begin
                fmt_q <= plf_pkg::plf_fmt_t'(new_fmt);
                ord_q <= plf_pkg::plf_ord_t'(new_ord);
            end
            if (fmt_chg) begin
                slots_q <= 3'h0;
                slot_en <= 4'h0;
            end else if (wr_cfg && slots_ok) begin
                slots_q <= new_slots;
                slot_en <= 4'(5'h0F >> (3'h4 - new_slots));
            end
            if (wr_ip)   ip_q   <= wdata;
            if (wr_mask) mask_q <= wdata;
            if (wr_gw)   gw_q   <= wdata;
            if (wr_map)  out_map_q <= wdata[IO_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // data word: clamp, select format, reorder bytes
    // ------------------------------------------------------------------
    function automatic logic [15:0] plf_clamp(input logic [31:0] v);
        if ($signed(v) > `PLF_WEIGHT_LIM) begin
            return 16'h7FFF;
        end else if ($signed(v) < -`PLF_WEIGHT_LIM) begin
            return 16'h8001;
        end
        return v[15:0];
    endfunction : plf_clamp

    wire [15:0] w_int = plf_clamp(weight_raw);
    wire [15:0] w_div = plf_clamp(div_raw);
    wire [31:0] w_sel = fmt_q == plf_pkg::PLF_FMT_INT ? 32'($signed(w_int))
                      : fmt_q == plf_pkg::PLF_FMT_DIV ? 32'($signed(w_div))
                      : float_raw;
    wire [31:0] w_ord =
        ord_q == plf_pkg::PLF_ORD_BYTE ? {w_sel[23:16], w_sel[31:24],
                                          w_sel[7:0],   w_sel[15:8]}
      : ord_q == plf_pkg::PLF_ORD_WORD ? {w_sel[15:0],  w_sel[31:16]}
      : ord_q == plf_pkg::PLF_ORD_DWRD ? {w_sel[7:0],   w_sel[15:8],
                                          w_sel[23:16], w_sel[31:24]}
      : w_sel;

    // ------------------------------------------------------------------
    // discrete I/O paced by the update cycle
    // ------------------------------------------------------------------
    wire [IO_W-1:0] dout_mix = (local_dout & out_map_q)
                             | (plc_dout & ~out_map_q);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dout      <= '0;
            plc_din   <= '0;
            data_word <= 32'h00000000;
        end else if (upd_tick) begin
            dout      <= dout_mix;
            plc_din   <= din;
            data_word <= w_ord;
        end
    end

    // ------------------------------------------------------------------
    // link, module status and activity indicators
    // ------------------------------------------------------------------
    wire flash1 = phase_q[2];
    wire flash2 = phase_q[1];
    wire flash4 = phase_q[0];
    plf_pkg::plf_led2_t mod_d;
    assign mod_d = net.fatal    ? {1'b0, flash4}
                 : net.cfg_fail ? {1'b0, flash2}
                 : net.dup_ip   ? {1'b0, 1'b1}
                 : net.mac_bad  ? {1'b0, flash1}
                 : !net.ip_set  ? {flash1, 1'b0}
                 : {1'b1, 1'b0};
    wire fault = net.fatal | net.cfg_fail | net.dup_ip | net.mac_bad;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            led_link  <= 1'b0;
            led_mod   <= '0;
            led_act   <= 1'b0;
            act_cnt_q <= 32'h00000000;
        end else begin
            led_link <= net.link;
            led_mod  <= mod_d;
            if (net.pkt) begin
                act_cnt_q <= ACT_CYC;
            end else if (act_cnt_q != 32'h00000000) begin
                act_cnt_q <= act_cnt_q - 32'h00000001;
            end
            led_act <= net.pkt || act_cnt_q > 32'h00000001;
        end
    end

    // ------------------------------------------------------------------
    // connection count blinker
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bl_q      <= plf_pkg::PLF_BL_PAUSE;
            bl_cnt_q  <= 4'h0;
            bl_left_q <= 4'h0;
            led_net   <= 1'b0;
        end else if (tick) begin
            case (bl_q)
                plf_pkg::PLF_BL_PAUSE: begin
                    if (bl_cnt_q + 4'h1 >= `PLF_BLINK_PAUSE) begin
                        bl_cnt_q <= 4'h0;
                        if (net.conns != 4'h0) begin
                            bl_left_q <= net.conns - 4'h1;
                            bl_q      <= plf_pkg::PLF_BL_ON;
                            led_net   <= 1'b1;
                        end
                    end else begin
                        bl_cnt_q <= bl_cnt_q + 4'h1;
                    end
                end
                plf_pkg::PLF_BL_ON: begin
                    led_net <= 1'b0;
                    bl_q    <= bl_left_q == 4'h0 ? plf_pkg::PLF_BL_PAUSE
                                                 : plf_pkg::PLF_BL_OFF;
                end
                plf_pkg::PLF_BL_OFF: begin
                    led_net   <= 1'b1;
                    bl_left_q <= bl_left_q - 4'h1;
                    bl_q      <= plf_pkg::PLF_BL_ON;
                end
                default: begin
                    bl_q    <= plf_pkg::PLF_BL_PAUSE;
                    led_net <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // events, interrupt and read data
    // ------------------------------------------------------------------
    wire [3:0] evt_set = {fmt_chg, net.conns != conns_q,
                          fault & ~fault_q, net.link ^ link_q};
    wire [3:0] evt_d   = evt_set | (rd_evt ? 4'h0 : evt_q);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evt_q      <= 4'h0;
            evt_mask_q <= 4'h0;
            link_q     <= 1'b0;
            fault_q    <= 1'b0;
            conns_q    <= 4'h0;
            irq        <= 1'b0;
            rdata      <= 32'h00000000;
        end else begin
            evt_q   <= evt_d;
            link_q  <= net.link;
            fault_q <= fault;
            conns_q <= net.conns;
            if (wr_emask) begin
                evt_mask_q <= wdata[3:0];
            end
            irq <= |(evt_d & (wr_emask ? wdata[3:0] : evt_mask_q));
            case (rd ? addr : 8'hFF)
                `PLF_A_CFG:      rdata <= cfg_rd;
                `PLF_A_IP:       rdata <= ip_q;
                `PLF_A_NETMASK:  rdata <= mask_q;
                `PLF_A_GATEWAY:  rdata <= gw_q;
                `PLF_A_HWADDR_L: rdata <= HW_ADDR[31:0];
                `PLF_A_HWADDR_H: rdata <= {16'h0000, HW_ADDR[47:32]};
                `PLF_A_STATUS:   rdata <= stat_rd;
                `PLF_A_EVT:      rdata <= {28'h0000000, evt_q};
                `PLF_A_EVT_MASK: rdata <= {28'h0000000, evt_mask_q};
                `PLF_A_OUT_MAP:  rdata <= 32'(out_map_q);
                `PLF_A_WORD:     rdata <= data_word;
                default:         rdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_io_paced;
        !upd_tick |=> $stable(dout) && $stable(plc_din);
    endproperty
    a_io_paced: assert property (p_io_paced)
        else $error("discrete io changed off the update cycle");

    property p_local_wins;
        upd_tick && !wr_map
        |=> (dout & out_map_q) == ($past(local_dout) & out_map_q);
    endproperty
    a_local_wins: assert property (p_local_wins)
        else $error("plc drove a locally mapped output");

    property p_net_locked;
        !opt_q && wr && addr == `PLF_A_IP |=> $stable(ip_q);
    endproperty
    a_net_locked: assert property (p_net_locked)
        else $error("network register written before option seen");

    property p_fmt_clears;
        fmt_chg |=> slot_en == 4'h0 && slots_q == 3'h0;
    endproperty
    a_fmt_clears: assert property (p_fmt_clears)
        else $error("format change left slots configured");

    property p_int_clamp;
        fmt_q == plf_pkg::PLF_FMT_INT && ord_q == plf_pkg::PLF_ORD_STD
        && upd_tick && ($signed(weight_raw) > `PLF_WEIGHT_LIM
        || $signed(weight_raw) < -`PLF_WEIGHT_LIM)
        |=> data_word == ($past(weight_raw[31]) ? 32'hFFFF8001 : 32'h00007FFF);
    endproperty
    a_int_clamp: assert property (p_int_clamp)
        else $error("integer weight not clamped");

    property p_slot_range;
        slots_q <= `PLF_SLOT_MAX && $countones(slot_en) == int'(slots_q);
    endproperty
    a_slot_range: assert property (p_slot_range)
        else $error("slot count out of range");

    property p_link_led;
        net.link ##1 net.link |-> led_link;
    endproperty
    a_link_led: assert property (p_link_led)
        else $error("link indicator off while linked");

    property p_dup_red;
        net.dup_ip && !net.fatal && !net.cfg_fail
        |=> led_mod.red && !led_mod.grn;
    endproperty
    a_dup_red: assert property (p_dup_red)
        else $error("duplicate address not steady red");

    property p_fatal_top;
        net.fatal |=> !led_mod.grn && led_mod.red == $past(flash4);
    endproperty
    a_fatal_top: assert property (p_fatal_top)
        else $error("fatal error not shown first");

    property p_act_flash;
        net.pkt |=> led_act;
    endproperty
    a_act_flash: assert property (p_act_flash)
        else $error("packet did not light activity");

    property p_no_conn_dark;
        net.conns == 4'h0 && bl_q == plf_pkg::PLF_BL_PAUSE |=> !led_net;
    endproperty
    a_no_conn_dark: assert property (p_no_conn_dark)
        else $error("network indicator lit with no connection");
endmodule : plf_top
`default_nettype wire

// file: verilog/plf_regs.svh
// Purpose: register offsets, field positions, reset values and timing
// Assumes: 40 MHz system clock
// Notes:   offsets are byte addresses of aligned words
`ifndef PLF_REGS_SVH
`define PLF_REGS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PLF_A_CFG      8'h00
`define PLF_A_IP       8'h04
`define PLF_A_NETMASK  8'h08
`define PLF_A_GATEWAY  8'h0C
`define PLF_A_HWADDR_L 8'h10
`define PLF_A_HWADDR_H 8'h14
`define PLF_A_STATUS   8'h18
`define PLF_A_EVT      8'h1C
`define PLF_A_EVT_MASK 8'h20
`define PLF_A_OUT_MAP  8'h24
`define PLF_A_WORD     8'h28
// ----------------------------------------------------------------------
// config fields and reset values
// ----------------------------------------------------------------------
`define PLF_CFG_FMT_LSB   0
`define PLF_CFG_ORD_LSB   2
`define PLF_CFG_SLOT_LSB  4
`define PLF_FMT_RST       2'h0
`define PLF_ORD_RST       2'h2
`define PLF_SLOT_RST      3'h1
`define PLF_SLOT_MAX      3'h4
`define PLF_WEIGHT_LIM    32'sh00007FFF
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PLF_CLK_KHZ       40000
`define PLF_TICK_MS       125
`define PLF_UPDATE_MS     58
`define PLF_ACT_MS        25
`define PLF_TICK_CYC      (`PLF_TICK_MS * `PLF_CLK_KHZ)
`define PLF_UPDATE_CYC    (`PLF_UPDATE_MS * `PLF_CLK_KHZ)
`define PLF_ACT_CYC       (`PLF_ACT_MS * `PLF_CLK_KHZ)
`define PLF_BLINK_PAUSE   4'h6
`endif

// file: verilog/plf_pkg.sv
// Purpose: types of the link status and data format block
// Assumes: nothing
// Notes:   constants live in plf_regs.svh
`default_nettype none
package plf_pkg;
    typedef enum logic [1:0] {
        PLF_FMT_INT  = 2'h0,
        PLF_FMT_DIV  = 2'h1,
        PLF_FMT_FLT  = 2'h2,
        PLF_FMT_APP  = 2'h3
    } plf_fmt_t;
    typedef enum logic [1:0] {
        PLF_ORD_STD  = 2'h0,
        PLF_ORD_BYTE = 2'h1,
        PLF_ORD_WORD = 2'h2,
        PLF_ORD_DWRD = 2'h3
    } plf_ord_t;
    typedef enum logic [1:0] {
        PLF_BL_PAUSE = 2'h0,
        PLF_BL_ON    = 2'h1,
        PLF_BL_OFF   = 2'h2
    } plf_blink_t;
    // network condition inputs, all levels except pkt
    typedef struct packed {
        logic       link;
        logic       ip_set;
        logic       mac_bad;
        logic       cfg_fail;
        logic       fatal;
        logic       dup_ip;
        logic       pkt;
        logic [3:0] conns;
    } plf_net_t;
    // module status indicator drive
    typedef struct packed {
        logic grn;
        logic red;
    } plf_led2_t;
endpackage : plf_pkg
`default_nettype wire

// file: tb/plf_net_model.sv
// Purpose: far side model, network conditions and plc outputs
// Assumes: requests change just after a rising edge
// Notes:   each toggle of pkt_tgl gives one pkt pulse of one cycle
`default_nettype none
module plf_net_model (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire plf_pkg::plf_net_t want,
    input  wire logic              pkt_tgl,
    input  wire logic [3:0]        plc_want,
    output plf_pkg::plf_net_t      net,
    output logic [3:0]             plc_dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tgl_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            net      <= '0;
            tgl_q    <= 1'b0;
            plc_dout <= 4'h0;
        end else begin
            tgl_q    <= pkt_tgl;
            net      <= {want[10:5], pkt_tgl ^ tgl_q, want.conns};
            plc_dout <= plc_want;
        end
    end
endmodule : plf_net_model
`default_nettype wire

// file: tb/plc_link_status_and_format_tb.sv
// Purpose: self-checking bench for the status and format block
// Assumes: 8 cycle tick, 10 cycle update, 3 cycle activity
// Notes:   flash rates are counted as toggles per 128 cycles
`include "plf_regs.svh"
`default_nettype none
module plc_link_status_and_format_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk_sys, rstn, wr, rd, opt_present, pkt_tgl;
    logic               led_link, led_net, led_act, irq;
    logic [7:0]         addr;
    logic [31:0]        wdata, rdata, weight_raw, div_raw, data_word;
    logic [31:0]        g, r, b, lo;
    logic [3:0]         plc_want, plc_dout, local_dout, din, dout;
    logic [3:0]         plc_din, slot_en;
    plf_pkg::plf_net_t  want, net;
    plf_pkg::plf_led2_t led_mod;
    int                 failures, total_checks;
    localparam logic [3:0]  CF [7] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1,
        4'h2, 4'h3};
    localparam logic [31:0] EX [7] = '{32'hFFFF8001, 32'hFFFF0180,
        32'h8001FFFF, 32'h0180FFFF, 32'h00007FFF, 32'hFFFF63C0,
        32'hFFFF63C0};
    plf_top #(.TICK_CYC(8), .UPDATE_CYC(10), .ACT_CYC(3)) uut (
        .clk_sys, .rstn, .addr, .wdata, .wr, .rd, .rdata, .opt_present,
        .net, .weight_raw, .div_raw, .float_raw(weight_raw), .plc_dout,
        .local_dout, .din, .dout, .plc_din, .data_word, .slot_en,
        .led_link, .led_mod, .led_net, .led_act, .irq);
    plf_net_model model (.clk_sys, .rstn, .want, .pkt_tgl, .plc_want,
        .net, .plc_dout);
    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        rd   <= 1'b1;
        addr <= a;
        cyc(1);
        rd   <= 1'b0;
        chk(rdata, e);
    endtask : rd_chk
    task automatic cnt(input int n);
        plf_pkg::plf_led2_t m;
        logic               nt;
        int                 run;
        cyc(2);
        {g, r, b, lo} = '0;
        run = 0;
        m = led_mod;
        nt = led_net;
        repeat (n) begin
            cyc(1);
            g += 32'(led_mod.grn != m.grn);
            r += 32'(led_mod.red != m.red);
            b += 32'(led_net && !nt);
            run = led_net ? 0 : run + 1;
            if (32'(run) > lo) lo = 32'(run);
            m = led_mod;
            nt = led_net;
        end
    endtask : cnt
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rstn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rd_chk(`PLF_A_CFG, 32'h00000018);
        chk({28'h0, slot_en}, 32'h1);
    endtask : t_reset
    task automatic t_regs();
        wr_reg(`PLF_A_IP, 32'hC0A80005);
        rd_chk(`PLF_A_IP, 32'h0);
        opt_present <= 1'b1;
        cyc(2);
        wr_reg(`PLF_A_IP, 32'hC0A80005);
        wr_reg(`PLF_A_GATEWAY, 32'h0A000001);
        rd_chk(`PLF_A_IP, 32'hC0A80005);
        rd_chk(`PLF_A_GATEWAY, 32'h0A000001);
        wr_reg(`PLF_A_NETMASK, 32'hFFFFFF00);
        rd_chk(`PLF_A_NETMASK, 32'hFFFFFF00);
        wr_reg(`PLF_A_HWADDR_L, 32'h0);
        rd_chk(`PLF_A_HWADDR_L, 32'h00000001);
        rd_chk(`PLF_A_HWADDR_H, 32'h00000200);
        rd_chk(8'h3C, 32'h0);
    endtask : t_regs
    task automatic t_fmt();
        wr_reg(`PLF_A_CFG, 32'h49);
        cyc(2);
        chk({28'h0, slot_en}, 32'h0);
        chk1(irq, 1'b0);
        wr_reg(`PLF_A_CFG, 32'h49);
        wr_reg(`PLF_A_CFG, 32'h59);
        cyc(2);
        chk({28'h0, slot_en}, 32'hF);
        rd_chk(`PLF_A_EVT, 32'h8);
        wr_reg(`PLF_A_EVT_MASK, 32'h8);
        wr_reg(`PLF_A_CFG, 32'h48);
        cyc(2);
        chk1(irq, 1'b1);
        rd_chk(`PLF_A_EVT, 32'h8);
        cyc(2);
        chk1(irq, 1'b0);
    endtask : t_fmt
    task automatic t_data();
        wr_reg(`PLF_A_OUT_MAP, 32'h3);
        local_dout <= 4'h5;
        plc_want   <= 4'hA;
        din        <= 4'h6;
        weight_raw <= 32'hFFFF63C0;
        div_raw    <= 32'h00007FFF;
        for (int i = 0; i < 7; i++) begin
            wr_reg(`PLF_A_CFG, {25'h0, 3'h1, CF[i]});
            cyc(24);
            chk(data_word, EX[i]);
        end
        chk({28'h0, dout}, 32'h9);
        chk({28'h0, plc_din}, 32'h6);
        rd_chk(`PLF_A_OUT_MAP, 32'h3);
        rd_chk(`PLF_A_WORD, 32'hFFFF63C0);
        plc_want <= 4'h4;
        @(posedge clk_sys);
        weight_raw <= 32'h5;
        repeat (12) begin
            cyc(1);
            chk1(dout === 4'h5, data_word === 32'h5);
        end
        chk({28'h0, dout}, 32'h5);
    endtask : t_data
    task automatic t_leds();
        rd_chk(`PLF_A_EVT, 32'h8);
        chk1(led_act, 1'b0);
        want.link <= 1'b1;
        cnt(128);
        chk1(led_link, 1'b1);
        chk(g, 32'h4);
        want.ip_set  <= 1'b1;
        want.mac_bad <= 1'b1;
        cnt(128);
        chk(r, 32'h4);
        want.cfg_fail <= 1'b1;
        cnt(128);
        chk(r, 32'h8);
        want.fatal <= 1'b1;
        cnt(128);
        chk(r, 32'h10);
        want.fatal    <= 1'b0;
        want.cfg_fail <= 1'b0;
        want.dup_ip   <= 1'b1;
        cnt(128);
        chk({r[29:0], led_mod}, 32'h1);
        want.conns <= 4'h3;
        cnt(176);
        chk(b, 32'h6);
        chk1(lo >= 32'h00000030, 1'b1);
        rd_chk(`PLF_A_STATUS, 32'h0000039E);
        pkt_tgl <= ~pkt_tgl;
        cyc(2);
        chk1(led_act, 1'b1);
        cyc(8);
        chk1(led_act, 1'b0);
        want.link <= 1'b0;
        cyc(3);
        chk1(led_link, 1'b0);
        rd_chk(`PLF_A_EVT, 32'h7);
    endtask : t_leds
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        $display("mismatch at %0t: watchdog expired", $time);
        failures++;
        print_verdict();
    end
    initial begin
        {rstn, wr, rd, opt_present, pkt_tgl, addr, wdata} = '0;
        {weight_raw, div_raw, plc_want, local_dout, din, want} = '0;
        t_reset();
        t_regs();
        t_fmt();
        t_data();
        t_leds();
        t_reset();
        print_verdict();
    end
endmodule : plc_link_status_and_format_tb
`default_nettype wire
